/* pkg/bsf_cfg.svh */
/*
 * constants of the bit, shift and flag execution unit:
 * wishbone byte offsets, command fields, flag positions.
 * assumes a 32-bit wishbone data bus and 8-bit address.
 */
`ifndef BSF_CFG_SVH
`define BSF_CFG_SVH

// register byte offsets
`define BSF_ADR_CMD 8'h00
`define BSF_ADR_STAT 8'h04
`define BSF_ADR_FLAGS 8'h08
`define BSF_ADR_PC 8'h0c
// window regions, selected by adr[7:5]
`define BSF_REG_WREG 3'h1
`define BSF_REG_IO 3'h2

// command word fields
`define BSF_OP_LSB 0
`define BSF_SEL_LSB 8
`define BSF_BIT_LSB 12
`define BSF_K_LSB 16

// status word bits
`define BSF_ST_BUSY 0
`define BSF_ST_TAKEN 1

// status flag positions
`define BSF_FC 0
`define BSF_FZ 1
`define BSF_FN 2
`define BSF_FV 3
`define BSF_FS 4
`define BSF_FT 6
`define BSF_FI 7

// reset values and pc step
`define BSF_FLAGS_RST 8'h00
`define BSF_PC_RST 16'h0000
`define BSF_PC_STEP 16'h0001

`endif

/* pkg/bsf_pkg.sv */
/*
 * types of the bit, shift and flag execution unit.
 * assumes bsf_cfg.svh is on the include path.
 */
package bsf_pkg;
`include "bsf_cfg.svh"

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_HOLD = 3'b100
    } bsf_state_t;

    typedef enum logic [4:0] {
        OP_JMPVCLR = 5'h00, OP_JMPIEN = 5'h01,
        OP_JMPIDIS = 5'h02, OP_IOSET = 5'h03,
        OP_IOCLR = 5'h04, OP_SHL = 5'h05,
        OP_SHR = 5'h06, OP_ROTL = 5'h07,
        OP_ROTR = 5'h08, OP_SHRA = 5'h09,
        OP_NIBSWP = 5'h0a, OP_FSET = 5'h0b,
        OP_FCLR = 5'h0c, OP_TSTORE = 5'h0d,
        OP_TLOAD = 5'h0e, OP_CSET = 5'h0f,
        OP_CCLR = 5'h10, OP_NSET = 5'h11,
        OP_NCLR = 5'h12, OP_ZSET = 5'h13,
        OP_ZCLR = 5'h14, OP_ISET = 5'h15,
        OP_ICLR = 5'h16, OP_SSET = 5'h17,
        OP_SCLR = 5'h18, OP_VSET = 5'h19,
        OP_VCLR = 5'h1a
    } bsf_op_t;

    typedef struct packed {
        bsf_state_t fsm;
        logic ack;
        logic [31:0] rdData;
        bsf_op_t op;
        logic [2:0] regSel;
        logic [2:0] bitSel;
        logic [6:0] kOff;
        logic taken;
        logic [7:0] flags;
        logic [15:0] pc;
        logic [7:0][7:0] wreg;
        logic [7:0][7:0] ioReg;
    } bsf_core_t;
endpackage

/* hw/bsf_exec_unit.sv */
/*
 * execution unit for branches on overflow and
 * interrupt flags, i/o bit set and clear, shifts,
 * rotates, nibble swap, transfer flag moves and
 * flag set and clear, with its own working and
 * i/o registers behind a classic wishbone slave.
 * assumes one clock, synchronous reset, and that
 * software waits for busy low between commands.
 */
`include "bsf_cfg.svh"
module bsf_exec_unit (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // core state
    output logic execBusy,
    output logic [7:0] statusFlags,
    output logic [15:0] progCount
);
    import bsf_pkg::*;

    bsf_core_t s;
    bsf_core_t next_s;

    // byte-lane merge of a write, used by every register
    function automatic logic [31:0] laneMerge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // flag position of a dedicated set or clear op
    function automatic logic [2:0] flagPos(
        input bsf_op_t op
    );
        case (op)
            OP_CSET, OP_CCLR: flagPos = 3'(`BSF_FC);
            OP_NSET, OP_NCLR: flagPos = 3'(`BSF_FN);
            OP_ZSET, OP_ZCLR: flagPos = 3'(`BSF_FZ);
            OP_ISET, OP_ICLR: flagPos = 3'(`BSF_FI);
            OP_SSET, OP_SCLR: flagPos = 3'(`BSF_FS);
            OP_VSET, OP_VCLR: flagPos = 3'(`BSF_FV);
            default: flagPos = 3'(`BSF_FC);
        endcase
    endfunction

    // level a dedicated op writes into its flag
    function automatic logic flagLevel(
        input bsf_op_t op
    );
        case (op)
            OP_CSET, OP_NSET, OP_ZSET,
            OP_ISET, OP_SSET, OP_VSET: flagLevel = 1'b1;
            default: flagLevel = 1'b0;
        endcase
    endfunction

    // next state: bus access first, execution after
    always_comb begin
        logic req;
        logic [31:0] wd;
        logic [7:0] r;
        logic [7:0] res;
        logic cOut;
        logic shiftOp;
        logic [2:0] ix;
        req = 1'b0;
        wd = 32'h0000_0000;
        r = 8'h00;
        res = 8'h00;
        cOut = 1'b0;
        shiftOp = 1'b0;
        ix = 3'h0;
        next_s = s;
        // ack drops the cycle after it was given
        next_s.ack = 1'b0;
        req = wb_cyc_i & wb_stb_i & ~s.ack;
        ix = wb_adr_i[4:2];
        if (req) begin
            next_s.ack = 1'b1;
            next_s.rdData = 32'h0000_0000;
            if (wb_we_i) begin
                case (wb_adr_i)
                    `BSF_ADR_CMD: begin
                        // a command while busy is dropped
                        if (s.fsm == ST_IDLE) begin
                            wd = laneMerge(32'h0000_0000,
                                wb_dat_i, wb_sel_i);
                            next_s.op = bsf_op_t'(
                                wd[`BSF_OP_LSB +: 5]);
                            next_s.regSel =
                                wd[`BSF_SEL_LSB +: 3];
                            next_s.bitSel =
                                wd[`BSF_BIT_LSB +: 3];
                            next_s.kOff = wd[`BSF_K_LSB +: 7];
                            next_s.fsm = ST_EXEC;
                        end
                    end
                    `BSF_ADR_FLAGS: begin
                        wd = laneMerge({24'h0, s.flags},
                            wb_dat_i, wb_sel_i);
                        next_s.flags = wd[7:0];
                    end
                    `BSF_ADR_PC: begin
                        wd = laneMerge({16'h0, s.pc},
                            wb_dat_i, wb_sel_i);
                        next_s.pc = wd[15:0];
                    end
                    default: begin
                        wd = laneMerge(32'h0000_0000,
                            wb_dat_i, wb_sel_i);
                        if (wb_adr_i[7:5] == `BSF_REG_WREG
                            && wb_sel_i[0]) begin
                            next_s.wreg[ix] = wd[7:0];
                        end
                        if (wb_adr_i[7:5] == `BSF_REG_IO
                            && wb_sel_i[0]) begin
                            next_s.ioReg[ix] = wd[7:0];
                        end
                    end
                endcase
            end else begin
                case (wb_adr_i)
                    `BSF_ADR_CMD: next_s.rdData = {9'h0,
                        s.kOff, 1'b0, s.bitSel, 1'b0,
                        s.regSel, 3'h0, s.op};
                    `BSF_ADR_STAT: begin
                        next_s.rdData[`BSF_ST_BUSY] =
                            (s.fsm != ST_IDLE);
                        next_s.rdData[`BSF_ST_TAKEN] =
                            s.taken;
                    end
                    `BSF_ADR_FLAGS:
                        next_s.rdData = {24'h0, s.flags};
                    `BSF_ADR_PC:
                        next_s.rdData = {16'h0, s.pc};
                    default: begin
                        if (wb_adr_i[7:5] == `BSF_REG_WREG)
                            next_s.rdData = {24'h0, s.wreg[ix]};
                        if (wb_adr_i[7:5] == `BSF_REG_IO)
                            next_s.rdData = {24'h0, s.ioReg[ix]};
                    end
                endcase
            end
        end

        // execution; it overrides a same-cycle bus write
        r = s.wreg[s.regSel];
        case (s.fsm)
            ST_IDLE: begin
                next_s.fsm = next_s.fsm;
            end
            ST_EXEC: begin
                next_s.fsm = ST_IDLE;
                next_s.taken = 1'b0;
                next_s.pc = s.pc + `BSF_PC_STEP;
                case (s.op)
                    OP_JMPVCLR: next_s.taken = ~s.flags[`BSF_FV];
                    OP_JMPIEN: next_s.taken = s.flags[`BSF_FI];
                    OP_JMPIDIS: next_s.taken = ~s.flags[`BSF_FI];
                    OP_IOSET: begin
                        next_s.ioReg[s.regSel][s.bitSel] = 1'b1;
                        next_s.fsm = ST_HOLD;
                    end
                    OP_IOCLR: begin
                        next_s.ioReg[s.regSel][s.bitSel] = 1'b0;
                        next_s.fsm = ST_HOLD;
                    end
                    OP_SHL: begin
                        res = {r[6:0], 1'b0};
                        cOut = r[7];
                        shiftOp = 1'b1;
                    end
                    OP_SHR: begin
                        res = {1'b0, r[7:1]};
                        cOut = r[0];
                        shiftOp = 1'b1;
                    end
                    OP_ROTL: begin
                        res = {r[6:0], s.flags[`BSF_FC]};
                        cOut = r[7];
                        shiftOp = 1'b1;
                    end
                    OP_ROTR: begin
                        res = {s.flags[`BSF_FC], r[7:1]};
                        cOut = r[0];
                        shiftOp = 1'b1;
                    end
                    OP_SHRA: begin
                        res = {r[7], r[7:1]};
                        cOut = r[0];
                        shiftOp = 1'b1;
                    end
                    OP_NIBSWP:
                        next_s.wreg[s.regSel] = {r[3:0], r[7:4]};
                    OP_FSET: next_s.flags[s.bitSel] = 1'b1;
                    OP_FCLR: next_s.flags[s.bitSel] = 1'b0;
                    OP_TSTORE:
                        next_s.flags[`BSF_FT] = r[s.bitSel];
                    OP_TLOAD: next_s.wreg[s.regSel][s.bitSel] =
                        s.flags[`BSF_FT];
                    OP_CSET, OP_CCLR, OP_NSET, OP_NCLR,
                    OP_ZSET, OP_ZCLR, OP_ISET, OP_ICLR,
                    OP_SSET, OP_SCLR, OP_VSET, OP_VCLR:
                        next_s.flags[flagPos(s.op)] =
                            flagLevel(s.op);
                    default: next_s.taken = 1'b0;
                endcase
                // taken branch adds k and a second cycle
                if (next_s.taken) begin
                    next_s.pc = s.pc
                        + 16'(signed'(s.kOff))
                        + `BSF_PC_STEP;
                    next_s.fsm = ST_HOLD;
                end
                // common shift flag update, v = n ^ c
                if (shiftOp) begin
                    next_s.wreg[s.regSel] = res;
                    next_s.flags[`BSF_FZ] = (res == 8'h00);
                    next_s.flags[`BSF_FC] = cOut;
                    next_s.flags[`BSF_FN] = res[7];
                    next_s.flags[`BSF_FV] = res[7] ^ cOut;
                end
            end
            // second cycle of two-cycle ops, no effect
            ST_HOLD: next_s.fsm = ST_IDLE;
            default: next_s.fsm = ST_IDLE;
        endcase

        // reset values override everything
        if (sys_rst) begin
            next_s = '0;
            next_s.fsm = ST_IDLE;
            next_s.op = OP_JMPVCLR;
            next_s.flags = `BSF_FLAGS_RST;
            next_s.pc = `BSF_PC_RST;
        end
    end

    // single state register
    always_ff @(posedge mclk) begin
        s <= next_s;
    end

    // outputs straight from flip-flops, execBusy decoded from the state
    assign wb_dat_o = s.rdData;
    assign wb_ack_o = s.ack;
    assign execBusy = (s.fsm != ST_IDLE);
    assign statusFlags = s.flags;
    assign progCount = s.pc;
endmodule

/* sim/bsf_exec_unit_asserts.sv */
/* checker of the exec unit: command timing and flag effects.
   assumes commands are written with byte lane 0 enabled. */
module bsf_exec_unit_asserts (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // core state
    input wire logic execBusy,
    input wire logic [7:0] statusFlags,
    input wire logic [15:0] progCount
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [17:0] FPOS = 18'h1ce50; // bit of c n z i s v
    logic cmdWr, brTake;
    logic [4:0] op;
    logic [31:0] cDat;
    logic [7:0] cFlg;
    logic [15:0] cPc, pcJump;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    function automatic logic [7:0] flagFx(input logic [7:0] f, input logic [4:0] o, input logic [2:0] b);
        logic [4:0] i;
        i = o - 5'h0f;
        if (o == 5'h0b || o == 5'h0c) f[b] = (o == 5'h0b);
        else if (o >= 5'h0f && o <= 5'h1a) f[FPOS[3 * i[3:1] +: 3]] = !i[0];
        return f;
    endfunction
    // writes while busy are dropped, so only idle ones count
    assign cmdWr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00 && wb_sel_i[0] && !execBusy;
    assign op = wb_dat_i[4:0];
    assign brTake = (op == 5'h00 && !statusFlags[3]) || (op == 5'h01 && statusFlags[7]) ||
        (op == 5'h02 && !statusFlags[7]);
    assign pcJump = cPc + {{9{cDat[22]}}, cDat[22:16]} + 16'h0001;
    // snapshot of the command and the state it started from
    always_ff @(posedge mclk) begin
        if (cmdWr) begin
            cDat <= wb_dat_i;
            cFlg <= statusFlags;
            cPc <= progCount;
        end
    end
    sequence oneCyc;
        execBusy ##1 !execBusy;
    endsequence
    sequence twoCyc;
        execBusy [*2] ##1 !execBusy;
    endsequence
    chk_vclr_jump: assert property (cmdWr && op == 5'h00 && brTake |=> twoCyc and ##1 progCount == pcJump)
        else $error("overflow branch missed target");
    chk_irq_jump: assert property (cmdWr && op != 5'h00 && brTake |=>
        twoCyc and ##1 (progCount == pcJump && statusFlags == cFlg)) else $error("irq branch wrong");
    chk_branch_skip: assert property (cmdWr && op <= 5'h02 && !brTake |=>
        oneCyc and ##1 progCount == cPc + 16'h0001) else $error("untaken branch wrong");
    chk_io_timing: assert property (cmdWr && (op == 5'h03 || op == 5'h04) |=>
        twoCyc and ##1 statusFlags == cFlg) else $error("io bit op timing or flags wrong");
    chk_shift_time: assert property (cmdWr && op >= 5'h05 && op <= 5'h09 |=>
        oneCyc and ##1 progCount == cPc + 16'h0001) else $error("shift not single cycle");
    chk_swap_keep: assert property (cmdWr && op == 5'h0a |=> oneCyc and ##1 statusFlags == cFlg)
        else $error("swap touched flags");
    chk_tstore_only: assert property (cmdWr && op == 5'h0d |=> ##1 (statusFlags & 8'hbf) == (cFlg & 8'hbf))
        else $error("bit store touched other flags");
    chk_tload_keep: assert property (cmdWr && op == 5'h0e |=> ##1 $stable(statusFlags))
        else $error("bit load touched flags");
    chk_flag_single: assert property (cmdWr && (op == 5'h0b || op == 5'h0c || op >= 5'h0f && op <= 5'h1a) |=>
        oneCyc and ##1 statusFlags == flagFx(cFlg, cDat[4:0], cDat[14:12])) else $error("flag op wrong");
endmodule

bind bsf_exec_unit bsf_exec_unit_asserts bsf_exec_unit_asserts_inst (
    .mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .execBusy(execBusy), .statusFlags(statusFlags), .progCount(progCount)
);

/* sim/bsf_exec_unit_tb.sv */
/* bench: commands over wishbone, reads checked against a model
   kept here. assumes one answer per request. */
module bsf_exec_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [17:0] FPOS = 18'h1ce50;
    logic mclk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, execBusy;
    logic [7:0] wb_adr_i, statusFlags, flg, v;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, got;
    logic [15:0] progCount, pc;
    logic [7:0] wr [8];
    logic [7:0] io [8];
    logic [31:0] expQ [$];
    logic [2:0] n;
    logic lastTk;
    int fails, cmp_count, cycles, seed;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("FAIL %0t %h %h", $time, a, b); end end
    bsf_exec_unit bsf_exec_unit_inst (
        .mclk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .execBusy, .statusFlags, .progCount
    );
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // hang guard, well above the 1200 or so cycles needed
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            conclude();
        end
    end
    // each read answer is matched against the oldest note
    always @(posedge mclk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            got = expQ.pop_front();
            `CHK(wb_dat_o, got)
        end
    end
    task automatic conclude;
        $display("compared %0d, mismatched %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [7:0] flagFx(input logic [7:0] f, input logic [4:0] o, input logic [2:0] b);
        logic [4:0] i;
        i = o - 5'h0f;
        if (o == 5'h0b || o == 5'h0c) f[b] = (o == 5'h0b);
        else if (o >= 5'h0f && o <= 5'h1a) f[FPOS[3 * i[3:1] +: 3]] = !i[0];
        return f;
    endfunction
    function automatic logic [7:0] ra(input logic [7:0] base, input logic [2:0] r);
        return base + {3'h0, r, 2'h0};
    endfunction
    // one classic cycle; waits for ack, then one idle cycle
    task automatic wbCyc(input logic [7:0] a, input logic w, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge mclk);
        while (wb_ack_o !== 1'b1) @(posedge mclk);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdExp(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        wbCyc(a, 1'b0, 32'h0);
    endtask
    task automatic setReg(input logic [7:0] base, input logic [2:0] r);
        v = 8'($random(seed));
        if (base == 8'h20) wr[r] = v;
        else io[r] = v;
        wbCyc(ra(base, r), 1'b1, {24'h0, v});
    endtask
    task automatic chkState;
        rdExp(8'h08, {24'h0, flg});
        rdExp(8'h0c, {16'h0, pc});
    endtask
    // model update first, then the command and the wait for idle
    task automatic cmd(input logic [4:0] o, input logic [2:0] r, input logic [2:0] b, input logic [6:0] k);
        logic [7:0] x;
        logic c;
        logic tk;
        x = wr[r];
        c = flg[0];
        tk = (o == 5'h00 && !flg[3]) || (o == 5'h01 && flg[7]) || (o == 5'h02 && !flg[7]);
        lastTk = tk;
        case (o)
            5'h03: io[r][b] = 1'b1;
            5'h04: io[r][b] = 1'b0;
            5'h05: {c, x} = {wr[r], 1'b0};
            5'h06: {x, c} = {1'b0, wr[r]};
            5'h07: {c, x} = {wr[r], flg[0]};
            5'h08: {x, c} = {flg[0], wr[r]};
            5'h09: {x, c} = {wr[r][7], wr[r]};
            5'h0a: x = {wr[r][3:0], wr[r][7:4]};
            5'h0d: flg[6] = wr[r][b];
            5'h0e: x[b] = flg[6];
            default: flg = flagFx(flg, o, b);
        endcase
        if (o >= 5'h05 && o <= 5'h09) flg[3:0] = {x[7] ^ c, x[7], x == 8'h00, c};
        wr[r] = x;
        pc = pc + 16'h0001 + (tk ? {{9{k[6]}}, k} : 16'h0000);
        wbCyc(8'h00, 1'b1, {9'h0, k, 1'b0, b, 1'b0, r, 3'h0, o});
        while (execBusy !== 1'b0) @(posedge mclk);
    endtask
    initial begin
        seed = 74162;
        {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {4'h8, 8'h00, 32'h0};
        wb_sel_i = 4'hf;
        flg = 8'h00;
        pc = 16'h0000;
        foreach (wr[i]) begin
            wr[i] = 8'h00;
            io[i] = 8'h00;
        end
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        // shifts, rotates and swap on random operands and carry
        for (int o = 5; o <= 10; o++) begin
            repeat (4) begin
                n = 3'($random(seed));
                setReg(8'h20, n);
                cmd(5'h0f + 5'($random(seed) & 1), 3'h0, 3'h0, 7'h0);
                cmd(5'(o), n, 3'h0, 7'h0);
                rdExp(ra(8'h20, n), {24'h0, wr[n]});
                chkState();
            end
        end
        $display("test shifts done");
        // bit into the transfer flag and back into another register
        repeat (8) begin
            n = 3'($random(seed));
            setReg(8'h20, n);
            cmd(5'h0d, n, 3'($random(seed)), 7'h0);
            cmd(5'h0e, n + 3'h1, 3'($random(seed)), 7'h0);
            rdExp(ra(8'h20, n + 3'h1), {24'h0, wr[n + 3'h1]});
            chkState();
        end
        $display("test transfer done");
        for (int o = 11; o <= 26; o++) begin
            repeat (2) begin
                if (o != 13 && o != 14) cmd(5'(o), 3'h0, 3'($random(seed)), 7'h0);
                chkState();
            end
        end
        $display("test flags done");
        repeat (8) begin
            n = 3'($random(seed));
            setReg(8'h40, n);
            cmd(5'h03 + 5'($random(seed) & 1), n, 3'($random(seed)), 7'h0);
            rdExp(ra(8'h40, n), {24'h0, io[n]});
        end
        $display("test io done");
        // random set or clear of i or v before each branch, so both outcomes occur
        for (int o = 0; o <= 2; o++) begin
            repeat (6) begin
                cmd(5'h15 + 5'($random(seed) & 5), 3'h0, 3'h0, 7'h0);
                cmd(5'(o), 3'h0, 3'h0, 7'($random(seed)));
                chkState();
                rdExp(8'h04, {30'h0, lastTk, 1'b0});
            end
        end
        rdExp(8'h1c, 32'h0);
        $display("test branches done");
        conclude();
    end
endmodule
